// file: tmr_regs.vh
// Summary of operation
// - software reads and writes the 8-bit count; a write replaces it
// - after a count write, no compare match on the next timer tick
// - compare value A is matched against the count; sets flag or drives output A
// - compare value B is matched against the count; sets flag or drives output B
// - compare B request needs its enable, global enable and flag all set
// - compare A request needs its enable, global enable and flag all set
// - overflow request needs its enable, global enable and flag all set
// - compare B flag is set when the count equals compare value B
// - compare B flag clears on vector entry or on a written one
// - compare A flag is set when the count equals compare value A
// - compare A flag clears on vector entry or on a written one
// - overflow flag is set when the counter overflows
// - overflow flag clears on vector entry or on a written one
// - the count that sets the overflow flag depends on the waveform mode
// - upper bits of mask and flag registers read as zero
// - a forced compare strobe changes only the waveform output, never a flag
`ifndef TMR_REGS_VH
`define TMR_REGS_VH
`define TMR_OFF_CTRL   12'h000
`define TMR_OFF_COUNT  12'h004
`define TMR_OFF_CMPA   12'h008
`define TMR_OFF_CMPB   12'h00c
// the mask offset is kept as a word index, so it is word aligned; byte address is four times it
`define TMR_IDX_MASK   10'h06e
`define TMR_OFF_MASK   {`TMR_IDX_MASK, 2'h0}
`define TMR_OFF_FLAGS  12'h010
`define TMR_OFF_VECACK 12'h014
`define TMR_BIT_OVF    0
`define TMR_BIT_CMPA   1
`define TMR_BIT_CMPB   2
`define TMR_BIT_FOCA   6
`define TMR_BIT_FOCB   7
`define TMR_MAX        8'hff
`define TMR_BOTTOM     8'h00
`define TMR_ZERO8      8'h00
`endif

// file: tmr_timer8.v
`timescale 1ns/1ps
`include "tmr_regs.vh"
// ctrl layout: [2:0] clock select (0 stop, else tick every core_clk),
// [5:3] waveform_mode_sel, [6] force_cmp_a_strobe, [7] force strobe b (write only)
// [9:8] compare output mode a, [11:10] compare output mode b
module tmr_timer8 (
   input  wire        core_clk,
   input  wire        rst,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   input  wire        global_irq_en,
   output reg         irq,
   output reg         irq_cmp_a,
   output reg         irq_cmp_b,
   output reg         irq_ovf,
   output reg         wave_out_a,
   output reg         wave_out_b
);
   localparam ST_IDLE = 1'b0;
   localparam ST_ACK  = 1'b1;

   reg         st_r;
   reg [11:0]  ctrl_r;
   reg [7:0]   counter_value_r;
   reg [7:0]   compare_value_a_r;
   reg [7:0]   compare_value_b_r;
   reg [2:0]   mask_r;
   reg [2:0]   flags_r;
   reg         dir_down_r;
   reg         block_r;
   reg [7:0]   counter_value_nxt;
   reg         dir_down_nxt;
   reg [2:0]   set_ev;
   reg [2:0]   clr_ev;
   reg         wave_a_nxt;
   reg         wave_b_nxt;
   reg [31:0]  rd_nxt;
   reg         hit;

   wire        acc      = psel & penable & (st_r == ST_IDLE);
   wire        wr       = acc & pwrite;
   wire [2:0]  wgm      = ctrl_r[5:3];
   wire        running  = (ctrl_r[2:0] != 3'h0);
   wire        tick     = running;
   wire        pwm      = wgm[0];
   wire        ocr_top  = wgm[2] | (wgm == 3'h2);
   wire [7:0]  top      = ocr_top ? compare_value_a_r : `TMR_MAX;
   wire        m_a      = (counter_value_r == compare_value_a_r);
   wire        m_b      = (counter_value_r == compare_value_b_r);

   function [1:0] sel_hit;
      input [11:0] a;
      begin
         sel_hit = 2'h0;
         if (a == `TMR_OFF_COUNT) sel_hit = 2'h1;
         if (a == `TMR_OFF_FLAGS) sel_hit = 2'h2;
      end
   endfunction

   function wave_apply;
      input       cur;
      input [1:0] com;
      input       up;
      begin
         case (com)
            2'h1: wave_apply = ~cur;
            2'h2: wave_apply = ~up;
            2'h3: wave_apply = up;
            default: wave_apply = cur;
         endcase
      end
   endfunction

   // counter sequence per mode
   always @* begin
      counter_value_nxt = counter_value_r;
      dir_down_nxt      = dir_down_r;
      set_ev            = 3'h0;
      wave_a_nxt        = wave_out_a;
      wave_b_nxt        = wave_out_b;
      if (tick) begin
         case (wgm)
            3'h1, 3'h5: begin
               if (!dir_down_r && counter_value_r == top) begin
                  dir_down_nxt      = 1'b1;
                  counter_value_nxt = counter_value_r - 8'h01;
               end else if (dir_down_r && counter_value_r == `TMR_BOTTOM) begin
                  dir_down_nxt      = 1'b0;
                  counter_value_nxt = counter_value_r + 8'h01;
                  set_ev[`TMR_BIT_OVF] = 1'b1;
               end else if (dir_down_r) begin
                  counter_value_nxt = counter_value_r - 8'h01;
               end else begin
                  counter_value_nxt = counter_value_r + 8'h01;
               end
            end
            3'h2, 3'h7, 3'h3: begin
               if (counter_value_r == top) begin
                  counter_value_nxt = `TMR_BOTTOM;
                  if (wgm != 3'h2 || top == `TMR_MAX)
                     set_ev[`TMR_BIT_OVF] = 1'b1;
               end else begin
                  counter_value_nxt = counter_value_r + 8'h01;
                  // ctc with the count above top still wraps at max
                  if (wgm == 3'h2 && counter_value_r == `TMR_MAX)
                     set_ev[`TMR_BIT_OVF] = 1'b1;
               end
            end
            default: begin
               counter_value_nxt = counter_value_r + 8'h01;
               if (counter_value_r == `TMR_MAX)
                  set_ev[`TMR_BIT_OVF] = 1'b1;
            end
         endcase
         // compare matches are blocked on the tick after a count write
         if (!block_r) begin
            set_ev[`TMR_BIT_CMPA] = m_a;
            set_ev[`TMR_BIT_CMPB] = m_b;
            if (m_a)
               wave_a_nxt = wave_apply(wave_out_a, ctrl_r[9:8], ~dir_down_r);
            if (m_b)
               wave_b_nxt = wave_apply(wave_out_b, ctrl_r[11:10], ~dir_down_r);
         end
      end
      // forced strobes: waveform only, non-pwm modes only, no flag
      if (wr && paddr == `TMR_OFF_CTRL && !pwm) begin
         if (pwdata[`TMR_BIT_FOCA])
            wave_a_nxt = wave_apply(wave_out_a, ctrl_r[9:8], 1'b1);
         if (pwdata[`TMR_BIT_FOCB])
            wave_b_nxt = wave_apply(wave_out_b, ctrl_r[11:10], 1'b1);
      end
      // a count write overrides the sequence
      if (wr && sel_hit(paddr) == 2'h1)
         counter_value_nxt = pwdata[7:0];
   end

   // write-one-to-clear and vector acknowledge
   always @* begin
      clr_ev = 3'h0;
      if (wr && sel_hit(paddr) == 2'h2)
         clr_ev = pwdata[2:0];
      if (wr && paddr == `TMR_OFF_VECACK)
         clr_ev = clr_ev | pwdata[2:0];
   end

   always @* begin
      hit    = 1'b1;
      rd_nxt = 32'h0;
      case (paddr)
         `TMR_OFF_CTRL:   rd_nxt = {20'h0, ctrl_r[11:8], 2'h0, ctrl_r[5:0]};
         `TMR_OFF_COUNT:  rd_nxt = {24'h0, counter_value_r};
         `TMR_OFF_CMPA:   rd_nxt = {24'h0, compare_value_a_r};
         `TMR_OFF_CMPB:   rd_nxt = {24'h0, compare_value_b_r};
         `TMR_OFF_MASK:   rd_nxt = {29'h0, mask_r};
         `TMR_OFF_FLAGS:  rd_nxt = {29'h0, flags_r};
         `TMR_OFF_VECACK: rd_nxt = 32'h0;
         default:         hit = 1'b0;
      endcase
   end

   always @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_r              <= ST_IDLE;
         prdata            <= 32'h0;
         pready            <= 1'b0;
         pslverr           <= 1'b0;
         ctrl_r            <= 12'h000;
         counter_value_r   <= `TMR_ZERO8;
         compare_value_a_r <= `TMR_ZERO8;
         compare_value_b_r <= `TMR_ZERO8;
         mask_r            <= 3'h0;
         flags_r           <= 3'h0;
         dir_down_r        <= 1'b0;
         block_r           <= 1'b0;
         irq               <= 1'b0;
         irq_cmp_a         <= 1'b0;
         irq_cmp_b         <= 1'b0;
         irq_ovf           <= 1'b0;
         wave_out_a        <= 1'b0;
         wave_out_b        <= 1'b0;
      end else begin
         // one wait state: answer the cycle after the access phase opens
         st_r    <= acc ? ST_ACK : ST_IDLE;
         pready  <= acc;
         pslverr <= acc & ~hit;
         if (acc && !pwrite)
            prdata <= rd_nxt;
         if (wr) begin
            case (paddr)
               `TMR_OFF_CTRL: ctrl_r <= {pwdata[11:8], 2'h0, pwdata[5:0]};
               `TMR_OFF_CMPA: compare_value_a_r <= pwdata[7:0];
               `TMR_OFF_CMPB: compare_value_b_r <= pwdata[7:0];
               `TMR_OFF_MASK: mask_r <= pwdata[2:0];
               default: ;
            endcase
         end
         counter_value_r <= counter_value_nxt;
         dir_down_r      <= dir_down_nxt;
         // held until the next tick; the counter ticks every cycle when running
         if (wr && sel_hit(paddr) == 2'h1)
            block_r <= 1'b1;
         else if (tick)
            block_r <= 1'b0;
         // set wins over a same-cycle clear
         flags_r    <= (flags_r & ~clr_ev) | set_ev;
         wave_out_a <= wave_a_nxt;
         wave_out_b <= wave_b_nxt;
         // requests follow flag, enable and global enable as levels
         irq_cmp_b  <= flags_r[`TMR_BIT_CMPB] & mask_r[`TMR_BIT_CMPB] & global_irq_en;
         irq_cmp_a  <= flags_r[`TMR_BIT_CMPA] & mask_r[`TMR_BIT_CMPA] & global_irq_en;
         irq_ovf    <= flags_r[`TMR_BIT_OVF] & mask_r[`TMR_BIT_OVF] & global_irq_en;
         irq        <= |(flags_r & mask_r) & global_irq_en;
      end
   end
endmodule

// file: tmr_timer8_sva.sv
`timescale 1ns/1ps
`include "tmr_regs.vh"
module tmr_timer8_sva (
   input logic        core_clk,
   input logic        rst,
   input logic        psel,
   input logic        penable,
   input logic        pwrite,
   input logic [11:0] paddr,
   input logic [31:0] pwdata,
   input logic [31:0] prdata,
   input logic        pready,
   input logic        pslverr,
   input logic        global_irq_en,
   input logic        irq,
   input logic        irq_cmp_a,
   input logic        irq_cmp_b,
   input logic        irq_ovf
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   wire acc = psel && penable;
   sequence s_mask_off_a;
      acc && !pready && pwrite && paddr == `TMR_OFF_MASK && !pwdata[1];
   endsequence
   a_ready_pulse: assert property (pready |=> !pready) else $error("pready held");
   a_ready_cause: assert property (pready |-> $past(acc)) else $error("pready unasked");
   a_err_with_ready: assert property (pslverr |-> pready) else $error("pslverr alone");
   a_any_source: assert property (irq == (irq_cmp_a || irq_cmp_b || irq_ovf))
      else $error("irq not the sum of requests");
   a_cmpa_global: assert property (irq_cmp_a |-> $past(global_irq_en))
      else $error("cmp a request without global enable");
   a_cmpb_global: assert property (irq_cmp_b |-> $past(global_irq_en))
      else $error("cmp b request without global enable");
   a_ovf_global: assert property (irq_ovf |-> $past(global_irq_en))
      else $error("overflow request without global enable");
   a_mask_off_a: assert property (s_mask_off_a |=> ##1 !irq_cmp_a)
      else $error("cmp a request while disabled");
   a_rsvd_zero: assert property (pready && !pwrite && (paddr == `TMR_OFF_MASK ||
      paddr == `TMR_OFF_FLAGS) |-> prdata[31:3] == 29'h0) else $error("upper bits set");
   a_request_holds: assert property (irq_cmp_a && global_irq_en && !acc |=> irq_cmp_a)
      else $error("cmp a request dropped");
endmodule

// file: timer8_compare_irq_regs_tb.sv
`timescale 1ns/1ps
`include "tmr_regs.vh"
module timer8_compare_irq_regs_tb;
   reg         core_clk = 1'b0;
   reg         rst = 1'b1;
   reg         psel = 1'b0;
   reg         penable = 1'b0;
   reg         pwrite = 1'b0;
   reg  [11:0] paddr = 12'h000;
   reg  [31:0] pwdata = 32'h0;
   reg         global_irq_en = 1'b0;
   wire [31:0] prdata;
   wire        pready, pslverr, irq, irq_cmp_a, irq_cmp_b, irq_ovf, wave_out_a, wave_out_b;
   integer     miscompares = 0;
   integer     num_checks = 0;
   integer     cycles = 0;
   reg  [31:0] q;
   reg         e;
   always #2 core_clk = ~core_clk;
   tmr_timer8 u_dut (.core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .global_irq_en(global_irq_en), .irq(irq), .irq_cmp_a(irq_cmp_a),
      .irq_cmp_b(irq_cmp_b), .irq_ovf(irq_ovf), .wave_out_a(wave_out_a),
      .wave_out_b(wave_out_b));
   task complete_run;
      begin
         $display("checks %0d mismatches %0d", num_checks, miscompares);
         if (miscompares == 0 && num_checks > 0)
            $display("NO MISMATCHES");
         else
            $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   task chk(input [63:0] nm, input [31:0] x, input [31:0] g);
      begin
         num_checks = num_checks + 1;
         if (g !== x) begin
            miscompares = miscompares + 1;
            $display("unexpected %0s expected %h seen %h", nm, x, g);
         end
      end
   endtask
   // request held until pready is seen; only the watchdog ends a hang
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge core_clk);
         penable <= 1'b1;
         @(posedge core_clk);
         while (pready !== 1'b1)
            @(posedge core_clk);
         q = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge core_clk);
      end
   endtask
   task rd(input [11:0] a, input [63:0] nm, input [31:0] x);
      begin
         apb(1'b0, a, 32'h0);
         chk(nm, x, q);
      end
   endtask
   task t_regs;
      begin
         rd(`TMR_OFF_MASK, "mask", 32'h0);
         apb(1'b1, `TMR_OFF_MASK, 32'hff);
         rd(`TMR_OFF_MASK, "mask", 32'h7);
         apb(1'b1, `TMR_OFF_COUNT, 32'h5a);
         rd(`TMR_OFF_COUNT, "count", 32'h5a);
         apb(1'b0, 12'h0f0, 32'h0);
         chk("slverr", 32'h1, {31'h0, e});
         chk("rd_err", 32'h0, q);
      end
   endtask
   task t_flags;
      begin
         apb(1'b1, `TMR_OFF_CMPA, 32'h20);
         apb(1'b1, `TMR_OFF_CMPB, 32'h30);
         apb(1'b1, `TMR_OFF_COUNT, 32'h10);
         apb(1'b1, `TMR_OFF_CTRL, 32'h1);
         // one full wrap passes both compare values and the top
         repeat (300) @(posedge core_clk);
         apb(1'b1, `TMR_OFF_CTRL, 32'h0);
         rd(`TMR_OFF_FLAGS, "flags", 32'h7);
         global_irq_en <= 1'b1;
         repeat (2) @(posedge core_clk);
         chk("irqs", 32'hf, {28'h0, irq, irq_cmp_b, irq_cmp_a, irq_ovf});
         apb(1'b1, `TMR_OFF_MASK, 32'h5);
         chk("irqs", 32'hd, {28'h0, irq, irq_cmp_b, irq_cmp_a, irq_ovf});
         global_irq_en <= 1'b0;
         repeat (2) @(posedge core_clk);
         chk("irqs", 32'h0, {28'h0, irq, irq_cmp_b, irq_cmp_a, irq_ovf});
         apb(1'b1, `TMR_OFF_FLAGS, 32'h2);
         rd(`TMR_OFF_FLAGS, "flags", 32'h5);
         apb(1'b1, `TMR_OFF_VECACK, 32'h4);
         rd(`TMR_OFF_FLAGS, "flags", 32'h1);
         apb(1'b1, `TMR_OFF_FLAGS, 32'h1);
         rd(`TMR_OFF_FLAGS, "flags", 32'h0);
      end
   endtask
   task t_block;
      begin
         apb(1'b1, `TMR_OFF_COUNT, 32'h0);
         apb(1'b1, `TMR_OFF_CMPA, 32'h40);
         apb(1'b1, `TMR_OFF_CTRL, 32'h1);
         apb(1'b1, `TMR_OFF_COUNT, 32'h40);
         apb(1'b1, `TMR_OFF_CTRL, 32'h0);
         rd(`TMR_OFF_FLAGS, "flags", 32'h0);
         // output modes must already stand when the strobes are written
         apb(1'b1, `TMR_OFF_CTRL, 32'h500);
         apb(1'b1, `TMR_OFF_CTRL, 32'h5c0);
         rd(`TMR_OFF_FLAGS, "flags", 32'h0);
         chk("wave_a", 32'h1, {31'h0, wave_out_a});
         chk("wave_b", 32'h1, {31'h0, wave_out_b});
      end
   endtask
   task t_modes;
      begin
         apb(1'b1, `TMR_OFF_CMPA, 32'h8);
         apb(1'b1, `TMR_OFF_COUNT, 32'h0);
         apb(1'b1, `TMR_OFF_CTRL, 32'h11);
         repeat (40) @(posedge core_clk);
         apb(1'b1, `TMR_OFF_CTRL, 32'h0);
         rd(`TMR_OFF_FLAGS, "flags", 32'h2);
         apb(1'b1, `TMR_OFF_FLAGS, 32'h7);
         apb(1'b1, `TMR_OFF_COUNT, 32'h4);
         apb(1'b1, `TMR_OFF_CTRL, 32'h29);
         repeat (40) @(posedge core_clk);
         apb(1'b1, `TMR_OFF_CTRL, 32'h0);
         rd(`TMR_OFF_FLAGS, "flags", 32'h3);
      end
   endtask
   initial begin
      repeat (4) @(posedge core_clk);
      rst <= 1'b0;
      @(posedge core_clk);
      t_regs;
      t_flags;
      t_block;
      t_modes;
      complete_run;
   end
   always @(posedge core_clk) begin
      cycles = cycles + 1;
      if (cycles == 3000) begin
         miscompares = miscompares + 1;
         complete_run;
      end
   end
endmodule
bind tmr_timer8 tmr_timer8_sva u_sva (.core_clk(core_clk), .rst(rst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .global_irq_en(global_irq_en), .irq(irq),
   .irq_cmp_a(irq_cmp_a), .irq_cmp_b(irq_cmp_b), .irq_ovf(irq_ovf));
